// >>> hw/dmrc_chan_seq.sv
/*
  Run sequencer of one DMA channel: idle, armed, running.
  Assumes arm and disarm are one-cycle requests, never together.
*/
`timescale 1ns/1ns
module dmrc_chan_seq (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst_b,
  // Control
  input  wire logic                enable,
  input  wire logic                arm,
  input  wire logic                disarm,
  input  wire logic                trigger,
  input  wire logic                done,
  // Status
  output logic                     pending,
  output logic                     active,
  output dmrc_pkg::dmrc_evt_s      evt
);

  dmrc_pkg::dmrc_seq_e state;       // Current state
  dmrc_pkg::dmrc_seq_e next_state;  // Next state
  dmrc_pkg::dmrc_evt_s next_evt;    // Next event pulses

  // Stopped clock means no trigger or completion is seen
  always_comb begin
    next_state = state;
    case (state)
      dmrc_pkg::DMRC_IDLE: begin
        // Arming waits for a trigger, never starts at once; see RQ2
        if (arm) begin
          next_state = dmrc_pkg::DMRC_ARMED;
        end
      end
      dmrc_pkg::DMRC_ARMED: begin
        if (disarm) begin
          next_state = dmrc_pkg::DMRC_IDLE;
        end else if (enable && trigger) begin  // see RQ3, see RQ1
          next_state = dmrc_pkg::DMRC_RUN;
        end
      end
      dmrc_pkg::DMRC_RUN: begin
        // Abort wins over completion in the same cycle; see RQ6
        if (disarm) begin
          next_state = dmrc_pkg::DMRC_IDLE;
        end else if (enable && done) begin  // see RQ5
          next_state = dmrc_pkg::DMRC_IDLE;
        end
      end
      default: next_state = dmrc_pkg::DMRC_IDLE;
    endcase
  end

  // Pulses derived from the transition taken
  always_comb begin
    next_evt.start  = (state == dmrc_pkg::DMRC_ARMED) && (next_state == dmrc_pkg::DMRC_RUN);
    next_evt.abort  = (state != dmrc_pkg::DMRC_IDLE) && disarm;  // see RQ6, see RQ8
    next_evt.finish = (state == dmrc_pkg::DMRC_RUN) && !disarm && enable && done;  // see RQ13
  end

  // State and pulse registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= dmrc_pkg::DMRC_IDLE;  // see RQ9
      evt   <= '0;
    end else begin
      state <= next_state;
      evt   <= next_evt;
    end
  end

  // Pending until done or aborted; see RQ4
  assign pending = (state != dmrc_pkg::DMRC_IDLE);
  assign active  = (state == dmrc_pkg::DMRC_RUN);

endmodule

// >>> hw/dmrc_pkg.sv
/*
  Constants, types and helpers for the two-channel DMA run control block.
  Assumes a 32-bit Avalon-MM slave port with byte addresses and one clock.
*/
// Behaviour
// RQ1 - Enable bit 7 gates channel and clock
// RQ2 - Setting pending arms channel to await trigger
// RQ3 - Armed channel starts on software or selected trigger
// RQ4 - Pending reads one until transfer completes
// RQ5 - Hardware clears pending when transfer finishes
// RQ6 - Writing pending zero aborts running transfer
// RQ7 - Enable may change only while not pending
// RQ8 - Software stops: clear pending, then enable
// RQ9 - Reset clears both control registers
// RQ10 - Single-bit and whole-byte writes both accepted
// RQ11 - Two independent channels, each own register
// RQ12 - Bits six to one read zero
// RQ13 - Normal completion raises interrupt, abort does not
package dmrc_pkg;

  // Bus shape
  localparam int ADDR_W = 22;
  localparam int IDX_W  = 20;
  localparam int NUM_CH = 2;
  localparam int SEL_W  = 4;
  localparam int LANE_W = 8;
  localparam int SRC_MAX = 16;

  // Register indexes; byte address is four times the index
  localparam logic [19:0] IDX_RUN_CTL0   = 20'hfffbc;
  localparam logic [19:0] IDX_RUN_CTL1   = 20'hfffbd;
  localparam logic [19:0] IDX_IRQ_STATUS = 20'hfffc0;
  localparam logic [19:0] IDX_IRQ_MASK   = 20'hfffc1;
  localparam logic [19:0] IDX_TRIG_SEL   = 20'hfffc2;
  localparam logic [19:0] IDX_SW_TRIG    = 20'hfffc3;
  localparam logic [19:0] IDX_BIT_SET    = 20'hfffc4;
  localparam logic [19:0] IDX_BIT_CLR    = 20'hfffc5;

  // Field positions and reset values
  localparam int         RUN_ENABLE_BIT  = 7;
  localparam int         RUN_PENDING_BIT = 0;
  localparam logic [7:0] RUN_CTL_RESET   = 8'h00;
  localparam logic [1:0] IRQ_RESET       = 2'h0;
  localparam logic [3:0] TRIG_SEL_RESET  = 4'h0;

  // Kind of control write
  typedef enum logic [1:0] {DMRC_WR_BYTE, DMRC_WR_SET, DMRC_WR_CLR} dmrc_wr_e;

  // Channel sequencer states
  typedef enum logic [1:0] {DMRC_IDLE, DMRC_ARMED, DMRC_RUN} dmrc_seq_e;

  // Software-visible control flags of a channel
  typedef struct packed {
    logic enable;
    logic pending;
  } dmrc_ctl_s;

  // Event pulses out of a sequencer
  typedef struct packed {
    logic start;
    logic abort;
    logic finish;
  } dmrc_evt_s;

  // Flags requested by a byte, bit-set or bit-clear write
  function automatic dmrc_ctl_s dmrc_merge(dmrc_ctl_s cur, logic [7:0] d, dmrc_wr_e kind);
    dmrc_ctl_s r;
    r = cur;
    case (kind)
      DMRC_WR_BYTE: r = '{enable: d[RUN_ENABLE_BIT], pending: d[RUN_PENDING_BIT]};
      DMRC_WR_SET: begin
        r.enable  = cur.enable | d[RUN_ENABLE_BIT];
        r.pending = cur.pending | d[RUN_PENDING_BIT];
      end
      DMRC_WR_CLR: begin
        r.enable  = cur.enable & ~d[RUN_ENABLE_BIT];
        r.pending = cur.pending & ~d[RUN_PENDING_BIT];
      end
      default: r = cur;
    endcase
    return r;
  endfunction

endpackage

// >>> hw/dmrc_run_control.sv
/*
  Run control of a two-channel DMA controller with Avalon-MM registers.
  Assumes an external data mover that reports transfer completion.
*/
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ns
module dmrc_run_control #(
  parameter int NUM_SRC = 16  // Start sources wired in
) (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst_b,
  // Avalon-MM slave
  input  wire logic [dmrc_pkg::ADDR_W-1:0]  address,
  input  wire logic                         read,
  input  wire logic                         write,
  input  wire logic [31:0]                  writedata,
  input  wire logic [3:0]                   byteenable,
  output logic      [31:0]                  readdata,
  output logic                              waitrequest,
  // Trigger sources and data mover
  input  wire logic [NUM_SRC-1:0]           start_src,
  input  wire logic [dmrc_pkg::NUM_CH-1:0]  xfer_done,
  // Channel outputs
  output logic      [dmrc_pkg::NUM_CH-1:0]  chan_clk_en,
  output logic      [dmrc_pkg::NUM_CH-1:0]  xfer_start,
  output logic      [dmrc_pkg::NUM_CH-1:0]  xfer_active,
  output logic      [dmrc_pkg::NUM_CH-1:0]  xfer_abort,
  output logic      [dmrc_pkg::NUM_CH-1:0]  transfer_done_irq,
  // Interrupt
  output logic                              irq
);

  localparam int NCH = dmrc_pkg::NUM_CH;
  localparam int SW  = dmrc_pkg::SEL_W;
  localparam int LW  = dmrc_pkg::LANE_W;

  // A source list wider than the selector can address cannot be served
  if (NUM_SRC < 1 || NUM_SRC > dmrc_pkg::SRC_MAX) begin : g_bad_src
    $error("NUM_SRC must lie between 1 and 16");
  end

  // Bus handshake state
  logic served;                          // Second cycle of a request
  wire  req     = read | write;          // Any request
  wire  wr_go   = write & served;        // Write takes effect
  wire  rd_take = read & ~served;        // Read data captured

  // Register decode
  wire [dmrc_pkg::IDX_W-1:0] idx = address[dmrc_pkg::ADDR_W-1:2];
  wire hit_status = (idx == dmrc_pkg::IDX_IRQ_STATUS);
  wire hit_mask   = (idx == dmrc_pkg::IDX_IRQ_MASK);
  wire hit_sel    = (idx == dmrc_pkg::IDX_TRIG_SEL);
  wire hit_swtrig = (idx == dmrc_pkg::IDX_SW_TRIG);
  wire hit_set    = (idx == dmrc_pkg::IDX_BIT_SET);
  wire hit_clr    = (idx == dmrc_pkg::IDX_BIT_CLR);

  // Channel registers and status
  logic [NCH-1:0]         chan_en;       // Enable flags
  logic [NCH-1:0]         next_chan_en;  // Next enable flags
  logic [NCH-1:0][SW-1:0] trig_sel;      // Start source per channel
  logic [NCH-1:0][SW-1:0] next_trig_sel; // Next start source
  logic [NCH-1:0]         irq_status;    // Sticky completion flags
  logic [NCH-1:0]         next_status;   // Next sticky flags
  logic [NCH-1:0]         irq_mask;      // Interrupt mask
  logic [NCH-1:0]         next_mask;     // Next mask
  logic [NCH-1:0]         pend;          // Pending flags
  logic [NCH-1:0]         arm;           // Pending set request
  logic [NCH-1:0]         disarm;        // Pending clear request
  logic [NCH-1:0]         trig;          // Trigger seen
  logic [NCH-1:0]         sw_trig;       // Software trigger pulse
  logic [NCH-1:0]         hit_run;       // Control register hit
  logic [NCH-1:0][7:0]    run_byte;      // Control byte readback
  logic [31:0]            rd_mux;        // Selected read value

  // Unused selector codes see a quiet source
  wire [dmrc_pkg::SRC_MAX-1:0] src_pad = dmrc_pkg::SRC_MAX'(start_src);

  // One wait cycle on every access
  assign waitrequest = req & ~served;

  // Per-channel control; see RQ11
  for (genvar n = 0; n < NCH; n++) begin : g_ch
    dmrc_pkg::dmrc_ctl_s cur;           // Present flags
    dmrc_pkg::dmrc_ctl_s want;          // Flags asked by the write
    dmrc_pkg::dmrc_wr_e  kind;          // Byte, set or clear write
    dmrc_pkg::dmrc_evt_s evt;           // Sequencer pulses
    logic [7:0]          wdata;         // Byte aimed at this channel
    logic                wr_byte;       // Whole-byte write
    logic                wr_set;        // Bit-set write
    logic                wr_clr;        // Bit-clear write
    logic                any_wr;        // Any control write
    logic                stat_clr;      // Write-one-to-clear

    // Address of each channel register
    assign hit_run[n] = (idx == dmrc_pkg::IDX_W'(dmrc_pkg::IDX_RUN_CTL0 + n));

    // Byte writes use lane 0, bit writes the channel lane; see RQ10
    assign wr_byte = wr_go & hit_run[n] & byteenable[0];
    assign wr_set  = wr_go & hit_set & byteenable[n];
    assign wr_clr  = wr_go & hit_clr & byteenable[n];
    assign any_wr  = wr_byte | wr_set | wr_clr;
    assign wdata   = wr_byte ? writedata[7:0] : writedata[LW*n +: LW];
    assign kind    = wr_set ? dmrc_pkg::DMRC_WR_SET :
                     wr_clr ? dmrc_pkg::DMRC_WR_CLR : dmrc_pkg::DMRC_WR_BYTE;

    // Merge request with present flags
    assign cur  = '{enable: chan_en[n], pending: pend[n]};
    assign want = dmrc_pkg::dmrc_merge(cur, wdata, kind);

    // Writing one arms, writing zero aborts; see RQ2, see RQ6
    assign arm[n]    = any_wr & want.pending & ~pend[n];
    assign disarm[n] = any_wr & ~want.pending & pend[n];

    // Enable frozen while pending, so a stray write is dropped; see RQ7
    assign next_chan_en[n] = (any_wr & ~pend[n]) ? want.enable : chan_en[n];

    // Start source select, one nibble per lane
    assign next_trig_sel[n] = (wr_go & hit_sel & byteenable[n]) ? writedata[LW*n +: SW] : trig_sel[n];

    // Software trigger or selected source; see RQ3
    assign sw_trig[n] = wr_go & hit_swtrig & byteenable[0] & writedata[n];
    assign trig[n]    = sw_trig[n] | src_pad[trig_sel[n]];

    // Completion sets, a one clears; a set wins; see RQ13
    assign stat_clr       = wr_go & hit_status & byteenable[0] & writedata[n];
    assign next_status[n] = evt.finish | (irq_status[n] & ~stat_clr);

    // Readback: bits six to one read zero; see RQ12, see RQ4
    assign run_byte[n] = {chan_en[n], 6'h00, pend[n]};

    // Sequencer of this channel
    dmrc_chan_seq u_seq (
      .clk     (clk),
      .rst_b   (rst_b),
      .enable  (chan_en[n]),
      .arm     (arm[n]),
      .disarm  (disarm[n]),
      .trigger (trig[n]),
      .done    (xfer_done[n]),
      .pending (pend[n]),
      .active  (xfer_active[n]),
      .evt     (evt)
    );

    // Pulse outputs from sequencer flops
    assign xfer_start[n]        = evt.start;
    assign xfer_abort[n]        = evt.abort;
    assign transfer_done_irq[n] = evt.finish;

    // A disabled channel never starts
    property p_gate_start;
      @(posedge clk) disable iff (!rst_b)
      xfer_start[n] |-> $past(chan_en[n]);
    endproperty
    a_gate_start: assert property (p_gate_start) else $error("start while disabled"); // see RQ1

    // Arming waits, it does not run at once
    property p_arm_wait;
      @(posedge clk) disable iff (!rst_b)
      arm[n] |=> pend[n] && !xfer_active[n] && !xfer_start[n];
    endproperty
    a_arm_wait: assert property (p_arm_wait) else $error("arm did not wait"); // see RQ2

    // Trigger on an armed, enabled channel starts it next cycle
    property p_trig_start;
      @(posedge clk) disable iff (!rst_b)
      (pend[n] && !xfer_active[n] && chan_en[n] && trig[n] && !disarm[n]) |=> xfer_start[n] && xfer_active[n];
    endproperty
    a_trig_start: assert property (p_trig_start) else $error("trigger ignored"); // see RQ3

    // Running implies pending
    property p_pend_busy;
      @(posedge clk) disable iff (!rst_b)
      xfer_active[n] |-> pend[n] && run_byte[n][dmrc_pkg::RUN_PENDING_BIT];
    endproperty
    a_pend_busy: assert property (p_pend_busy) else $error("busy without pending"); // see RQ4

    // Completion clears pending and pulses once
    property p_auto_clear;
      @(posedge clk) disable iff (!rst_b)
      (xfer_active[n] && chan_en[n] && xfer_done[n] && !disarm[n])
        |=> !pend[n] && transfer_done_irq[n] ##1 !transfer_done_irq[n];
    endproperty
    a_auto_clear: assert property (p_auto_clear) else $error("no auto clear"); // see RQ5

    // Abort stops the run without a completion
    property p_abort;
      @(posedge clk) disable iff (!rst_b)
      (xfer_active[n] && disarm[n]) |=> !xfer_active[n] && xfer_abort[n] && !transfer_done_irq[n];
    endproperty
    a_abort: assert property (p_abort) else $error("abort failed"); // see RQ6

    // Enable holds while pending
    property p_en_locked;
      @(posedge clk) disable iff (!rst_b)
      pend[n] |=> $stable(chan_en[n]);
    endproperty
    a_en_locked: assert property (p_en_locked) else $error("enable changed while pending"); // see RQ7

    // Control byte is zero after reset
    property p_reset_zero;
      @(posedge clk) disable iff (!rst_b)
      $rose(rst_b) |-> run_byte[n] == dmrc_pkg::RUN_CTL_RESET && !xfer_active[n];
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("control not cleared"); // see RQ9

    // Bit-set of pending arms an idle channel
    property p_bit_set;
      @(posedge clk) disable iff (!rst_b)
      (wr_set && wdata[dmrc_pkg::RUN_PENDING_BIT] && !pend[n]) |=> pend[n];
    endproperty
    a_bit_set: assert property (p_bit_set) else $error("bit set lost"); // see RQ10

    // Sticky flag holds until cleared
    property p_sticky;
      @(posedge clk) disable iff (!rst_b)
      (irq_status[n] && !stat_clr) |=> irq_status[n];
    endproperty
    a_sticky: assert property (p_sticky) else $error("status not sticky"); // see RQ13
  end

  // Mask write
  assign next_mask = (wr_go & hit_mask & byteenable[0]) ? writedata[NCH-1:0] : irq_mask;

  // Read select; unmapped reads return zero
  assign rd_mux = hit_run[0] ? {24'h000000, run_byte[0]} :
                  hit_run[1] ? {24'h000000, run_byte[1]} :
                  hit_status ? {30'h0, irq_status} :
                  hit_mask   ? {30'h0, irq_mask} :
                  hit_sel    ? {16'h0000, 4'h0, trig_sel[1], 4'h0, trig_sel[0]} :
                  32'h00000000;

  // Reserved bits of a control read are zero
  property p_reserved;
    @(posedge clk) disable iff (!rst_b)
    (rd_take && |hit_run) |=> readdata[6:1] == 6'h00 && readdata[31:8] == 24'h000000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set"); // see RQ12

  // Bus and register state
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      served     <= 1'b0;
      readdata   <= 32'h00000000;
      chan_en    <= '0;  // see RQ9
      trig_sel   <= {NCH{dmrc_pkg::TRIG_SEL_RESET}};
      irq_status <= dmrc_pkg::IRQ_RESET;
      irq_mask   <= dmrc_pkg::IRQ_RESET;
    end else begin
      served     <= req & ~served;
      readdata   <= rd_take ? rd_mux : readdata;
      chan_en    <= next_chan_en;
      trig_sel   <= next_trig_sel;
      irq_status <= next_status;
      irq_mask   <= next_mask;
    end
  end

  // Clock gate follows enable; see RQ1
  assign chan_clk_en = chan_en;

  // Level interrupt while an unmasked flag stands
  assign irq = |(irq_status & irq_mask);

endmodule

// >>> test/tb.sv
/*
  Self-checking bench for the two-channel DMA run control block.
  Assumes the package and design files are compiled ahead of it.
*/
`timescale 1ns/1ns
module tb;
  // Clock, reset and bus drive
  logic        clk         = 1'b0;
  logic        rst_b       = 1'b0;
  logic [21:0] address     = 22'h000000;
  logic        read        = 1'b0;
  logic        write       = 1'b0;
  logic [31:0] writedata   = 32'h00000000;
  logic [3:0]  byteenable  = 4'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  // Start sources and data mover
  logic [15:0] start_src   = 16'h0000;
  logic [1:0]  xfer_done   = 2'h0;
  // Channel outputs
  logic [1:0]  chan_clk_en;
  logic [1:0]  xfer_start;
  logic [1:0]  xfer_active;
  logic [1:0]  xfer_abort;
  logic [1:0]  transfer_done_irq;
  logic        irq;
  // Pulse tallies and bookkeeping
  int          n_start [2] = '{0, 0};
  int          n_abort [2] = '{0, 0};
  int          n_done  [2] = '{0, 0};
  int          error_cnt   = 0;
  int          n_checks    = 0;
  int          cyc         = 0;
  logic [31:0] rd;

  dmrc_run_control #(.NUM_SRC(16)) dut (
    .clk(clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .start_src(start_src), .xfer_done(xfer_done),
    .chan_clk_en(chan_clk_en), .xfer_start(xfer_start), .xfer_active(xfer_active),
    .xfer_abort(xfer_abort), .transfer_done_irq(transfer_done_irq), .irq(irq)
  );

  // Free-running 100 MHz clock
  always #5 clk = ~clk;

  // Tally one-cycle pulses so a short event is never missed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    for (int c = 0; c < 2; c++) begin
      if (xfer_start[c] === 1'b1) n_start[c] <= n_start[c] + 1;
      if (xfer_abort[c] === 1'b1) n_abort[c] <= n_abort[c] + 1;
      if (transfer_done_irq[c] === 1'b1) n_done[c] <= n_done[c] + 1;
    end
  end

  // Hang guard: the sequence needs well under a thousand cycles
  always @(posedge clk) begin
    if (cyc == 5000) begin
      error_cnt++;
      give_verdict();
    end
  end

  // Compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One Avalon access; request held until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [19:0] idx, input logic [31:0] d);
    @(posedge clk);
    address    <= {idx, 2'b00};
    writedata  <= d;
    byteenable <= 4'hf;
    write      <= wr;
    read       <= ~wr;
    @(posedge clk);
    // Only the hang guard ends a wait that never finishes
    while (waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    // Read data stand at the accepting edge
    rd = readdata;
    write <= 1'b0;
    read  <= 1'b0;
    // Let the accepting edge settle before anyone looks at outputs
    @(negedge clk);
  endtask

  task automatic wr(input logic [19:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rdc(input logic [19:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h00000000);
    chk(rd, exp);
  endtask

  // Let a few edges pass, then look at settled values
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  // One-cycle completion from the data mover
  task automatic fin(input int c);
    @(posedge clk);
    xfer_done[c] <= 1'b1;
    @(posedge clk);
    xfer_done[c] <= 1'b0;
    idle(2);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    // Reset contents
    rdc(dmrc_pkg::IDX_RUN_CTL0, 32'h00000000);
    rdc(dmrc_pkg::IDX_RUN_CTL1, 32'h00000000);
    rdc(dmrc_pkg::IDX_IRQ_STATUS, 32'h00000000);
    chk({30'h0, chan_clk_en}, 32'h0);
    // Arm channel 0; middle bits must not stick
    wr(dmrc_pkg::IDX_RUN_CTL0, 32'h000000ff);
    rdc(dmrc_pkg::IDX_RUN_CTL0, 32'h00000081);
    chk({30'h0, chan_clk_en}, 32'h1);
    idle(2);
    chk(n_start[0], 32'h0);
    wr(dmrc_pkg::IDX_IRQ_MASK, 32'h00000001);
    rdc(dmrc_pkg::IDX_IRQ_MASK, 32'h00000001);
    // Software trigger starts it; pending stays up while running
    wr(dmrc_pkg::IDX_SW_TRIG, 32'h00000001);
    idle(2);
    chk(n_start[0], 32'h1);
    chk({30'h0, xfer_active}, 32'h1);
    rdc(dmrc_pkg::IDX_RUN_CTL0, 32'h00000081);
    chk({31'h0, irq}, 32'h0);
    // Normal completion
    fin(0);
    chk(n_done[0], 32'h1);
    rdc(dmrc_pkg::IDX_RUN_CTL0, 32'h00000080);
    chk({31'h0, irq}, 32'h1);
    rdc(dmrc_pkg::IDX_IRQ_STATUS, 32'h00000001);
    wr(dmrc_pkg::IDX_IRQ_STATUS, 32'h00000001);
    chk({31'h0, irq}, 32'h0);
    // Re-arm; an enable change while pending is dropped
    wr(dmrc_pkg::IDX_RUN_CTL0, 32'h00000081);
    wr(dmrc_pkg::IDX_RUN_CTL0, 32'h00000001);
    rdc(dmrc_pkg::IDX_RUN_CTL0, 32'h00000081);
    // Abort while running: no completion request
    wr(dmrc_pkg::IDX_SW_TRIG, 32'h00000001);
    idle(2);
    chk({30'h0, xfer_active}, 32'h1);
    wr(dmrc_pkg::IDX_RUN_CTL0, 32'h00000080);
    idle(2);
    chk(n_abort[0], 32'h1);
    chk({30'h0, xfer_active}, 32'h0);
    chk(n_done[0], 32'h1);
    rdc(dmrc_pkg::IDX_IRQ_STATUS, 32'h00000000);
    wr(dmrc_pkg::IDX_RUN_CTL0, 32'h00000000);
    chk({30'h0, chan_clk_en}, 32'h0);
    // Channel 1 through bit set, started by source 5
    wr(dmrc_pkg::IDX_TRIG_SEL, 32'h00000500);
    wr(dmrc_pkg::IDX_BIT_SET, 32'h00008100);
    rdc(dmrc_pkg::IDX_RUN_CTL1, 32'h00000081);
    rdc(dmrc_pkg::IDX_RUN_CTL0, 32'h00000000);
    @(posedge clk);
    start_src <= 16'h0010;
    idle(3);
    chk(n_start[1], 32'h0);
    @(posedge clk);
    start_src <= 16'h0020;
    idle(3);
    chk(n_start[1], 32'h1);
    chk({30'h0, xfer_active}, 32'h2);
    @(posedge clk);
    start_src <= 16'h0000;
    fin(1);
    chk(n_done[1], 32'h1);
    rdc(dmrc_pkg::IDX_RUN_CTL1, 32'h00000080);
    // Masked status does not reach irq
    rdc(dmrc_pkg::IDX_IRQ_STATUS, 32'h00000002);
    chk({31'h0, irq}, 32'h0);
    wr(dmrc_pkg::IDX_IRQ_STATUS, 32'h00000002);
    rdc(dmrc_pkg::IDX_IRQ_STATUS, 32'h00000000);
    wr(dmrc_pkg::IDX_BIT_CLR, 32'h00008000);
    rdc(dmrc_pkg::IDX_RUN_CTL1, 32'h00000000);
    // Disabled channel holds pending and ignores triggers
    wr(dmrc_pkg::IDX_RUN_CTL1, 32'h00000001);
    wr(dmrc_pkg::IDX_SW_TRIG, 32'h00000002);
    idle(2);
    chk(n_start[1], 32'h1);
    chk({30'h0, chan_clk_en}, 32'h0);
    rdc(dmrc_pkg::IDX_RUN_CTL1, 32'h00000001);
    wr(dmrc_pkg::IDX_RUN_CTL1, 32'h00000000);
    // Dropping pending of an armed channel aborts it
    idle(1);
    chk(n_abort[1], 32'h1);
    // Unmapped place reads zero
    wr(20'h00010, 32'hffffffff);
    rdc(20'h00010, 32'h00000000);
    give_verdict();
  end
endmodule
